// file: rtl/reference_fringe_counter.v
`timescale 1ns/100ps
`default_nettype none
`include "fringe_defs.vh"

// Functional notes
// - Each sweep is framed by a fixed train of 21,294 sampling pulses.
// - Fringe counting starts at sampling pulse 5,324 of the sweep.
// - At pulse 21,294 the running fringe count is held as the whole-fringe count.
// - Interpolation ticks time full and partial fringes at window start and end.
// - A full fringe period is nominally about 232 ticks, within 3 ticks.
// - Partial fringe counters hold at least the range 0 to 235 ticks.
// - The interpolation clock splits each fringe about 232 ways, well over 57.
// - Interpolated count is whole count plus start ratio minus end ratio.
// - Sweep wavelength is 703.24 nm times interpolated count divided by 7,985.
// - One wavelength per sweep; a set holds 1 to 127 sweeps, 30 by default.
// - The number of sweeps performed in a set is reported with the results; sweeps_done clears to zero in the cycle set_mean is loaded.
// - A sweep is rejected when it deviates 28 ppm or more from the set mean.
// - After rejection the mean is recomputed from accepted sweeps only.
// - Below 75% accepted the new result is dropped and the old calibration kept.
module reference_fringe_counter #(
   parameter COUNT_W = 16,
   parameter SET_W = 7,
   parameter SET_DEPTH = 127,
   parameter [31:0] INITIAL_WAVELENGTH = 32'h5c631f80
) (
   input wire clock,
   input wire rst,
   input wire sweep_start,
   input wire sample_pulse,
   input wire fringe_in,
   input wire [SET_W-1:0] set_size,
   output reg [COUNT_W-1:0] whole_fringe_count,
   output reg [31:0] interpolated_fringe_count,
   output reg [31:0] sweep_wavelength,
   output reg sweep_valid,
   output reg [SET_W-1:0] sweeps_done,
   output reg [SET_W-1:0] accepted_count,
   output reg [31:0] set_mean,
   output reg [31:0] calibration_wavelength,
   output reg cal_updated,
   output reg cal_discarded
);

   localparam [3:0] ST_IDLE = 4'h0;
   localparam [3:0] ST_RAT_B = 4'h1;
   localparam [3:0] ST_RAT_E = 4'h2;
   localparam [3:0] ST_WAVE = 4'h3;
   localparam [3:0] ST_MEAN1 = 4'h4;
   localparam [3:0] ST_SCAN = 4'h5;
   localparam [3:0] ST_MEAN2 = 4'h6;
   localparam [3:0] ST_DECIDE = 4'h7;

   reg [3:0] state;
   reg [31:0] wl_mem [0:SET_DEPTH-1];
   reg [SET_W-1:0] target;
   reg [SET_W-1:0] idx;
   reg [39:0] acc_sum;
   reg [SET_W-1:0] acc_cnt;
   reg [31:0] mean1;
   reg [31:0] ratio_b;
   reg div_start;
   reg [63:0] div_a;
   reg [31:0] div_b;
   wire div_busy;
   wire div_done;
   wire [63:0] div_q;
   wire [COUNT_W-1:0] t_whole;
   wire [`TICK_CNT_W-1:0] t_begin;
   wire [`TICK_CNT_W-1:0] dt_begin;
   wire [`TICK_CNT_W-1:0] t_end;
   wire [`TICK_CNT_W-1:0] dt_end;
   wire capture;
   wire [31:0] next_interp;
   wire [31:0] scan_wl;
   wire scan_reject;

   // Fraction of a fringe as a 16-bit binary fraction
   function [63:0] frac_dividend;
      input [`TICK_CNT_W-1:0] part;
      begin
         frac_dividend = {{(64-`TICK_CNT_W){1'b0}}, part} << `FRAC_BITS;
      end
   endfunction

   // Relative deviation test against a mean, scaled to parts per million
   function outlier;
      input [31:0] value;
      input [31:0] mean;
      reg [31:0] diff;
      begin
         diff = (value >= mean) ? value - mean : mean - value;
         outlier = ({32'h0, diff} * {32'h0, `PPM_SCALE}) >=
                   ({32'h0, mean} * {32'h0, `REJECT_PPM});
      end
   endfunction

   fringe_timer #(
      .COUNT_W(COUNT_W),
      .INTERP_DIV(`INTERP_DIV)
   ) timer (
      .clock(clock),
      .rst(rst),
      .sweep_start(sweep_start),
      .sample_pulse(sample_pulse),
      .fringe_in(fringe_in),
      .whole_fringe_count(t_whole),
      .t_begin(t_begin),
      .dt_begin(dt_begin),
      .t_end(t_end),
      .dt_end(dt_end),
      .capture(capture)
   );

   seq_divider #(
      .DW(64),
      .VW(32),
      .CW(7)
   ) divider (
      .clock(clock),
      .rst(rst),
      .start(div_start),
      .dividend(div_a),
      .divisor(div_b),
      .busy(div_busy),
      .done(div_done),
      .quotient(div_q)
   );

   // Whole count in 16.16 form, plus start fraction, minus end fraction
   assign next_interp = ({t_whole, {`FRAC_BITS{1'b0}}} + ratio_b) - div_q[31:0];
   assign scan_wl = wl_mem[idx];
   assign scan_reject = outlier(scan_wl, mean1);

   // Per-sweep storage of wavelengths for the set statistics
   always @(posedge clock) begin
      if (state == ST_WAVE && div_done) begin
         wl_mem[sweeps_done] <= div_q[31:0];
      end
   end

   // Sweep computation and set statistics sequencer
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= ST_IDLE;
         target <= `SET_SIZE_DEFAULT;
         idx <= {SET_W{1'b0}};
         acc_sum <= 40'h0;
         acc_cnt <= {SET_W{1'b0}};
         mean1 <= 32'h0;
         ratio_b <= 32'h0;
         div_start <= 1'b0;
         div_a <= 64'h0;
         div_b <= 32'h0;
         whole_fringe_count <= {COUNT_W{1'b0}};
         interpolated_fringe_count <= 32'h0;
         sweep_wavelength <= 32'h0;
         sweep_valid <= 1'b0;
         sweeps_done <= {SET_W{1'b0}};
         accepted_count <= {SET_W{1'b0}};
         set_mean <= 32'h0;
         calibration_wavelength <= INITIAL_WAVELENGTH;
         cal_updated <= 1'b0;
         cal_discarded <= 1'b0;
      end else begin
         div_start <= 1'b0;
         sweep_valid <= 1'b0;
         cal_updated <= 1'b0;
         cal_discarded <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (capture) begin
                  if (sweeps_done == {SET_W{1'b0}}) begin
                     // Set size is taken at the first sweep; zero selects the default
                     target <= (set_size == {SET_W{1'b0}}) ? `SET_SIZE_DEFAULT : set_size;
                     acc_sum <= 40'h0;
                  end
                  whole_fringe_count <= t_whole;
                  div_a <= frac_dividend(dt_begin);
                  div_b <= {{(32-`TICK_CNT_W){1'b0}}, t_begin};
                  div_start <= 1'b1;
                  state <= ST_RAT_B;
               end
            end
            ST_RAT_B: begin
               if (div_done) begin
                  ratio_b <= div_q[31:0];
                  div_a <= frac_dividend(dt_end);
                  div_b <= {{(32-`TICK_CNT_W){1'b0}}, t_end};
                  div_start <= 1'b1;
                  state <= ST_RAT_E;
               end
            end
            ST_RAT_E: begin
               if (div_done) begin
                  interpolated_fringe_count <= next_interp;
                  div_a <= {32'h0, `REF_WAVELENGTH_FM} * {32'h0, next_interp};
                  div_b <= `WAVELENGTH_DIVISOR << `FRAC_BITS;
                  div_start <= 1'b1;
                  state <= ST_WAVE;
               end
            end
            ST_WAVE: begin
               if (div_done) begin
                  sweep_wavelength <= div_q[31:0];
                  sweep_valid <= 1'b1;
                  acc_sum <= acc_sum + {8'h0, div_q[31:0]};
                  sweeps_done <= sweeps_done + {{(SET_W-1){1'b0}}, 1'b1};
                  if (sweeps_done + {{(SET_W-1){1'b0}}, 1'b1} == target) begin
                     div_a <= {24'h0, acc_sum + {8'h0, div_q[31:0]}};
                     div_b <= {{(32-SET_W){1'b0}}, target};
                     div_start <= 1'b1;
                     state <= ST_MEAN1;
                  end else begin
                     state <= ST_IDLE;
                  end
               end
            end
            ST_MEAN1: begin
               if (div_done) begin
                  mean1 <= div_q[31:0];
                  idx <= {SET_W{1'b0}};
                  acc_sum <= 40'h0;
                  acc_cnt <= {SET_W{1'b0}};
                  state <= ST_SCAN;
               end
            end
            ST_SCAN: begin
               // Only sweeps inside the band enter the second mean
               if (!scan_reject) begin
                  acc_sum <= acc_sum + {8'h0, scan_wl};
                  acc_cnt <= acc_cnt + {{(SET_W-1){1'b0}}, 1'b1};
               end
               idx <= idx + {{(SET_W-1){1'b0}}, 1'b1};
               if (idx + {{(SET_W-1){1'b0}}, 1'b1} == target) begin
                  state <= ST_MEAN2;
               end
            end
            ST_MEAN2: begin
               if (!div_busy && !div_done) begin
                  div_a <= {24'h0, acc_sum};
                  div_b <= {{(32-SET_W){1'b0}}, acc_cnt};
                  div_start <= 1'b1;
                  state <= ST_DECIDE;
               end
            end
            ST_DECIDE: begin
               if (div_done) begin
                  set_mean <= div_q[31:0];
                  accepted_count <= acc_cnt;
                  sweeps_done <= {SET_W{1'b0}};
                  // Keep the old calibration when too few sweeps survive
                  if ({2'h0, acc_cnt} * `ACCEPT_DEN >= {2'h0, target} * `ACCEPT_NUM &&
                      acc_cnt != {SET_W{1'b0}}) begin
                     calibration_wavelength <= div_q[31:0];
                     cal_updated <= 1'b1;
                  end else begin
                     cal_discarded <= 1'b1;
                  end
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

endmodule // reference_fringe_counter

`default_nettype wire

// file: rtl/fringe_defs.vh
`ifndef FRINGE_DEFS_VH
`define FRINGE_DEFS_VH

// Sweep framing by sampling pulse number
`define SWEEP_PULSES 15'h532e
`define WINDOW_OPEN_PULSE 15'h14cc
`define PULSE_CNT_W 15

// Interpolation clock derived from the 125 MHz system clock
`define CLOCK_PERIOD_PS 8000
`define INTERP_PERIOD_PS 30303
`define INTERP_DIV ((`INTERP_PERIOD_PS + (`CLOCK_PERIOD_PS / 2)) / `CLOCK_PERIOD_PS)

// Interpolation counts per fringe
`define FULL_PERIOD_NOM 9'h0e8
`define FULL_PERIOD_TOL 9'h003
`define PARTIAL_MAX 9'h0eb
`define INTERP_MIN_FACTOR 9'h039
`define TICK_CNT_W 9
`define TICK_CNT_SAT 9'h1ff

// Fixed point and wavelength scaling (wavelengths in femtometres)
`define FRAC_BITS 16
`define REF_WAVELENGTH_FM 32'h29ea9740
`define WAVELENGTH_DIVISOR 32'h00001f31
`define REJECT_PPM 32'h0000001c
`define PPM_SCALE 32'h000f4240

// Calibration set sizing and acceptance
`define SET_SIZE_DEFAULT 7'h1e
`define ACCEPT_NUM 9'h003
`define ACCEPT_DEN 9'h004

`endif

// file: rtl/seq_divider.v
`timescale 1ns/100ps
`default_nettype none

// Restoring divider, one quotient bit per clock
module seq_divider #(
   parameter DW = 64,
   parameter VW = 32,
   parameter CW = 7
) (
   input wire clock,
   input wire rst,
   input wire start,
   input wire [DW-1:0] dividend,
   input wire [VW-1:0] divisor,
   output reg busy,
   output reg done,
   output reg [DW-1:0] quotient
);

   reg [VW-1:0] rem;
   reg [VW-1:0] dsr;
   reg [CW-1:0] steps;
   wire [VW:0] shifted;
   wire take;

   assign shifted = {rem, quotient[DW-1]};
   assign take = (shifted >= {1'b0, dsr});

   // Shift and subtract; a zero divisor gives all ones
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         busy <= 1'b0;
         done <= 1'b0;
         quotient <= {DW{1'b0}};
         rem <= {VW{1'b0}};
         dsr <= {VW{1'b0}};
         steps <= {CW{1'b0}};
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            busy <= 1'b1;
            quotient <= dividend;
            rem <= {VW{1'b0}};
            dsr <= divisor;
            steps <= DW[CW-1:0];
         end else if (busy) begin
            if (take) begin
               rem <= shifted[VW-1:0] - dsr;
               quotient <= {quotient[DW-2:0], 1'b1};
            end else begin
               rem <= shifted[VW-1:0];
               quotient <= {quotient[DW-2:0], 1'b0};
            end
            steps <= steps - {{(CW-1){1'b0}}, 1'b1};
            if (steps == {{(CW-1){1'b0}}, 1'b1}) begin
               busy <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end

endmodule // seq_divider

`default_nettype wire

// file: rtl/fringe_timer.v
`timescale 1ns/100ps
`default_nettype none
`include "fringe_defs.vh"

// Counts fringes in the window and times the partial fringes at both ends
module fringe_timer #(
   parameter COUNT_W = 16,
   parameter INTERP_DIV = `INTERP_DIV
) (
   input wire clock,
   input wire rst,
   input wire sweep_start,
   input wire sample_pulse,
   input wire fringe_in,
   output reg [COUNT_W-1:0] whole_fringe_count,
   output reg [`TICK_CNT_W-1:0] t_begin,
   output reg [`TICK_CNT_W-1:0] dt_begin,
   output reg [`TICK_CNT_W-1:0] t_end,
   output reg [`TICK_CNT_W-1:0] dt_end,
   output reg capture
);

   reg [`PULSE_CNT_W-1:0] pulse_cnt;
   reg [3:0] div_cnt;
   reg interp_tick;
   reg fringe_prev;
   reg window;
   reg [1:0] begin_phase;
   reg [COUNT_W-1:0] running;
   reg [`TICK_CNT_W-1:0] since_edge;
   reg [`TICK_CNT_W-1:0] last_period;
   wire edge_rise;
   wire [`PULSE_CNT_W-1:0] next_pulse_cnt;
   wire [`TICK_CNT_W-1:0] next_since;
   wire pulse_take;
   wire opening;
   wire closing;

   // Pulse bookkeeping runs beside edge counting; an edge in the opening or closing cycle is not counted
   assign pulse_take = sample_pulse && pulse_cnt != `SWEEP_PULSES;
   assign opening = pulse_take && next_pulse_cnt == `WINDOW_OPEN_PULSE;
   assign closing = pulse_take && next_pulse_cnt == `SWEEP_PULSES && window;
   assign edge_rise = fringe_in && !fringe_prev;
   assign next_pulse_cnt = pulse_cnt + {{(`PULSE_CNT_W-1){1'b0}}, 1'b1};
   assign next_since = (interp_tick && since_edge != `TICK_CNT_SAT) ?
                       since_edge + {{(`TICK_CNT_W-1){1'b0}}, 1'b1} : since_edge;

   // Interpolation clock enable from the system clock
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         div_cnt <= 4'h0;
         interp_tick <= 1'b0;
      end else begin
         interp_tick <= (div_cnt == INTERP_DIV[3:0] - 4'h1);
         div_cnt <= (div_cnt == INTERP_DIV[3:0] - 4'h1) ? 4'h0 : div_cnt + 4'h1;
      end
   end

   // Sampling pulse count, window framing, fringe and interval counting
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         pulse_cnt <= {`PULSE_CNT_W{1'b0}};
         fringe_prev <= 1'b0;
         window <= 1'b0;
         begin_phase <= 2'h0;
         running <= {COUNT_W{1'b0}};
         since_edge <= {`TICK_CNT_W{1'b0}};
         last_period <= {`TICK_CNT_W{1'b0}};
         whole_fringe_count <= {COUNT_W{1'b0}};
         t_begin <= {`TICK_CNT_W{1'b0}};
         dt_begin <= {`TICK_CNT_W{1'b0}};
         t_end <= {`TICK_CNT_W{1'b0}};
         dt_end <= {`TICK_CNT_W{1'b0}};
         capture <= 1'b0;
      end else begin
         fringe_prev <= fringe_in;
         capture <= 1'b0;
         if (sweep_start) begin
            pulse_cnt <= {`PULSE_CNT_W{1'b0}};
            window <= 1'b0;
            begin_phase <= 2'h0;
            running <= {COUNT_W{1'b0}};
            since_edge <= {`TICK_CNT_W{1'b0}};
            last_period <= {`TICK_CNT_W{1'b0}};
         end else begin
            if (pulse_take) begin
               pulse_cnt <= next_pulse_cnt;
            end
            if (opening) begin
               window <= 1'b1;
               running <= {COUNT_W{1'b0}};
               since_edge <= {`TICK_CNT_W{1'b0}};
               begin_phase <= 2'h1;
            end else if (closing) begin
               window <= 1'b0;
               whole_fringe_count <= running;
               dt_end <= next_since;
               t_end <= last_period;
               capture <= 1'b1;
            end
         end
         if (!sweep_start && !opening && !closing && window) begin
            // Counters cover 0..511, wider than a 235-count partial
            if (edge_rise) begin
               running <= running + {{(COUNT_W-1){1'b0}}, 1'b1};
               since_edge <= {`TICK_CNT_W{1'b0}};
               last_period <= next_since;
               if (begin_phase == 2'h1) begin
                  dt_begin <= next_since;
                  begin_phase <= 2'h2;
               end else if (begin_phase == 2'h2) begin
                  t_begin <= next_since;
                  begin_phase <= 2'h3;
               end
            end else begin
               since_edge <= next_since;
            end
         end
      end
   end

endmodule // fringe_timer

`default_nettype wire

// file: testbench/reference_fringe_counter_monitor.sv
`timescale 1ns/100ps
`default_nettype none

// Port-level checks on sweep results and calibration set decisions
module fringe_counter_monitor #(
   parameter COUNT_W = 16,
   parameter SET_W = 7
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic sweep_start,
   input wire logic sample_pulse,
   input wire logic fringe_in,
   input wire logic [SET_W-1:0] set_size,
   input wire logic [COUNT_W-1:0] whole_fringe_count,
   input wire logic [31:0] interpolated_fringe_count,
   input wire logic [31:0] sweep_wavelength,
   input wire logic sweep_valid,
   input wire logic [SET_W-1:0] sweeps_done,
   input wire logic [SET_W-1:0] accepted_count,
   input wire logic [31:0] set_mean,
   input wire logic [31:0] calibration_wavelength,
   input wire logic cal_updated,
   input wire logic cal_discarded
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   wire logic [63:0] wl_calc;
   wire logic [16:0] int_hi;
   wire logic [16:0] whole_x;

   // Reference scaling of the interpolated count, integer part beside the whole count
   assign wl_calc = (64'd703240000 * {32'h0, interpolated_fringe_count}) / (64'd7985 << 16);
   assign int_hi = {1'b0, interpolated_fringe_count[31:16]};
   assign whole_x = 17'(whole_fringe_count);

   valid_one_cycle_a: assert property (sweep_valid |=> !sweep_valid)
      else $error("sweep_valid held longer than one cycle");
   wl_scale_a: assert property (sweep_valid |-> {32'h0, sweep_wavelength} == wl_calc)
      else $error("sweep wavelength does not match interpolated count");
   int_part_a: assert property (sweep_valid |-> int_hi + 17'd2 >= whole_x && int_hi <= whole_x + 17'd1)
      else $error("interpolated count strays from whole count");
   wl_hold_a: assert property (!sweep_valid |-> $stable(sweep_wavelength))
      else $error("sweep wavelength changed without sweep_valid");
   done_step_a: assert property (sweep_valid |-> sweeps_done == $past(sweeps_done) + 1'b1)
      else $error("sweeps_done did not advance by one");
   count_to_result_a: assert property ($changed(whole_fringe_count) |-> ##[150:260] sweep_valid)
      else $error("captured count not followed by a result");
   cal_hold_a: assert property (!cal_updated |-> $stable(calibration_wavelength))
      else $error("calibration changed without cal_updated");
   cal_adopt_a: assert property (cal_updated |-> calibration_wavelength == set_mean)
      else $error("adopted calibration differs from set mean");
   accept_share_a: assert property ((cal_updated || cal_discarded) |-> (int'(accepted_count) * 4 >= int'($past(sweeps_done)) * 3) == cal_updated)
      else $error("set decision disagrees with accepted share");
   set_close_a: assert property ((cal_updated || cal_discarded) |-> sweeps_done == 0 && accepted_count <= $past(sweeps_done))
      else $error("set close counts inconsistent");

   cover property (sweep_valid && sweeps_done == 2);
   cover property (cal_updated);
   cover property (cal_discarded);
endmodule // fringe_counter_monitor

bind reference_fringe_counter fringe_counter_monitor #(.COUNT_W(COUNT_W), .SET_W(SET_W)) mon (
   .clock, .rst, .sweep_start, .sample_pulse, .fringe_in, .set_size, .whole_fringe_count,
   .interpolated_fringe_count, .sweep_wavelength, .sweep_valid, .sweeps_done, .accepted_count,
   .set_mean, .calibration_wavelength, .cal_updated, .cal_discarded);

`default_nettype wire

// file: testbench/fringe_source.sv
`timescale 1ns/100ps
`default_nettype none

// Sweep frame and reference fringe generator; fringes run through the whole sweep
module fringe_source (
   input wire logic clock,
   input wire logic rst,
   input wire logic go,
   input wire logic [15:0] period,
   input wire logic [15:0] phase,
   output logic sweep_start,
   output logic sample_pulse,
   output logic fringe_in
);
   localparam int SWEEP_LEN = 21294;
   localparam int OPEN_AT = 5325;
   int k;
   int idx;
   logic active;

   // Fringe phase of the coming cycle; rising edge when it wraps to zero
   always_comb idx = (k + 1 + 20 * int'(period) - OPEN_AT - int'(phase)) % int'(period);

   // Start pulse, then pulse number n in the cycle where k equals n
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         k <= 0;
         active <= 1'b0;
         sweep_start <= 1'b0;
         sample_pulse <= 1'b0;
         fringe_in <= 1'b0;
      end else begin
         sweep_start <= go;
         sample_pulse <= active && !go && k + 1 <= SWEEP_LEN;
         fringe_in <= active && !go && idx < int'(period) / 2;
         if (go) begin
            k <= 0;
            active <= 1'b1;
         end else if (active) begin
            k <= k + 1;
         end
      end
   end
endmodule // fringe_source

`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
   localparam [31:0] INIT_WL = 32'h5c631f80;
   localparam int LIMIT = 75000;
   logic clock;
   logic rst;
   logic go;
   logic [15:0] period;
   logic [15:0] phase;
   logic [6:0] set_size;
   wire logic sweep_start;
   wire logic sample_pulse;
   wire logic fringe_in;
   wire logic [15:0] whole_fringe_count;
   wire logic [31:0] interpolated_fringe_count;
   wire logic [31:0] sweep_wavelength;
   wire logic sweep_valid;
   wire logic [6:0] sweeps_done;
   wire logic [6:0] accepted_count;
   wire logic [31:0] set_mean;
   wire logic [31:0] calibration_wavelength;
   wire logic cal_updated;
   wire logic cal_discarded;
   int n_mismatch;
   int checked;
   int cycles;
   int seed;
   int p;
   int ph;
   logic [31:0] wl_a;
   logic [31:0] wl_b;

   fringe_source src (.clock, .rst, .go, .period, .phase, .sweep_start, .sample_pulse, .fringe_in);

   reference_fringe_counter #(.INITIAL_WAVELENGTH(INIT_WL)) DUT (
      .clock, .rst, .sweep_start, .sample_pulse, .fringe_in, .set_size, .whole_fringe_count,
      .interpolated_fringe_count, .sweep_wavelength, .sweep_valid, .sweeps_done,
      .accepted_count, .set_mean, .calibration_wavelength, .cal_updated, .cal_discarded);

   // Free-running system clock
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   task automatic complete_run();
      if (n_mismatch == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Cut a hang short
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles >= LIMIT) begin
         n_mismatch++;
         complete_run();
      end
   end

   task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic compare_near(input string what, input logic [31:0] exp,
                               input logic [31:0] got, input logic [31:0] tol);
      logic ok;
      ok = (got + tol >= exp) && (got <= exp + tol);
      checked++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Wait for a result pulse or a set close, bounded
   task automatic wait_for(input logic close, input int bound);
      int n;
      n = 0;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while ((close ? (cal_updated | cal_discarded) : sweep_valid) !== 1'b1 && n < bound);
      // A missing result counts as a mismatch and ends the run
      if ((close ? (cal_updated | cal_discarded) : sweep_valid) !== 1'b1) begin
         n_mismatch++;
         complete_run();
      end
   endtask

   // Edges must stay clear of window open and capture
   function automatic logic margin_ok(input int pp, input int q);
      int tail;
      tail = (21294 - 5325 - q) % pp;
      return tail >= 16 && tail <= pp - 16;
   endfunction

   function automatic int pick_phase(input int pp);
      int q;
      do q = 16 + int'($unsigned($random(seed)) % (pp / 2));
      while (!margin_ok(pp, q) || !margin_ok(pp, q + pp / 4));
      return q;
   endfunction

   // Whole count and start-minus-end partial ratio in 16.16
   task automatic expect_sweep(input int pp, input int q, output int whole, output longint interp);
      int e;
      int last;
      whole = 0;
      last = 0;
      for (e = 5325 + q; e < 21294; e += pp) begin
         whole++;
         last = e;
      end
      interp = longint'(whole) * 65536 + longint'(q) * 65536 / pp
               - longint'(21294 - last) * 65536 / pp;
   endtask

   task automatic run_sweep(input int pp, input int q, input int done_exp, output logic [31:0] wl);
      int whole;
      longint interp;
      longint wl_l;
      expect_sweep(pp, q, whole, interp);
      wl_l = 64'd703240000 * interp / (64'd7985 << 16);
      wl = wl_l[31:0];
      @(posedge clock);
      period <= pp[15:0];
      phase <= q[15:0];
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      wait_for(1'b0, 23000);
      compare("whole_fringe_count", 32'(whole), 32'(whole_fringe_count));
      compare_near("interpolated", interp[31:0], interpolated_fringe_count, 32'h600);
      compare_near("sweep_wavelength", wl, sweep_wavelength, 32'd2600);
      compare("sweeps_done", 32'(done_exp), 32'(sweeps_done));
   endtask

   initial begin
      seed = 32'he2c2;
      n_mismatch = 0;
      checked = 0;
      cycles = 0;
      rst = 1'b1;
      go = 1'b0;
      period = 16'd880;
      phase = 16'd100;
      set_size = 7'd1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1;
      compare("calibration_wavelength", INIT_WL, calibration_wavelength);
      // Single-sweep set is adopted
      p = 800 + int'($unsigned($random(seed)) % 100);
      ph = pick_phase(p);
      run_sweep(p, ph, 1, wl_a);
      wait_for(1'b1, 3000);
      compare("cal_updated", 32'h1, 32'(cal_updated));
      compare("accepted_count", 32'h1, 32'(accepted_count));
      compare_near("set_mean", wl_a, set_mean, 32'd2600);
      compare_near("calibration_wavelength", wl_a, calibration_wavelength, 32'd2600);
      // Two sweeps a quarter fringe apart: both out of family, old value kept
      @(posedge clock) set_size <= 7'd2;
      ph = pick_phase(p);
      run_sweep(p, ph, 1, wl_b);
      run_sweep(p, ph + p / 4, 2, wl_b);
      wait_for(1'b1, 3000);
      compare("cal_discarded", 32'h1, 32'(cal_discarded));
      compare("accepted_count", 32'h0, 32'(accepted_count));
      compare("sweeps_done", 32'h0, 32'(sweeps_done));
      compare_near("calibration_wavelength", wl_a, calibration_wavelength, 32'd2600);
      // Reset in mid-run restores the initial calibration
      @(posedge clock) rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1;
      compare("calibration_wavelength", INIT_WL, calibration_wavelength);
      complete_run();
   end
endmodule // tb

`default_nettype wire
